// ===== charge_ctrl_defs.vh
`ifndef CHARGE_CTRL_DEFS_VH
`define CHARGE_CTRL_DEFS_VH

// Register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_IRQ_STATUS 8'h08
`define REG_IRQ_MASK 8'h0c

// Control register fields
`define CTRL_SOFT_SUSPEND 0
`define CTRL_RESET 1'b0

// Status register fields
`define STAT_STATE_LSB 0
`define STAT_FAULT_HELD 8
`define STAT_THERMAL 9
`define STAT_AC 10
`define STAT_USB 11
`define STAT_PIN_A 12
`define STAT_PIN_B 13
`define STAT_PIN_PG 14

// Interrupt bits
`define IRQ_FAULT 0
`define IRQ_DONE 1
`define IRQ_SLEEP 2
`define IRQ_THERMAL 3
`define IRQ_WIDTH 4
`define IRQ_MASK_RESET 4'h0

// Timing
`define CLK_PERIOD_NS 100
`define TICK_TIME_NS 1000000
`define TICK_CYCLES (`TICK_TIME_NS / `CLK_PERIOD_NS)
`define PRECHARGE_TIME_MS 1800000
`define FASTCHARGE_TIME_MS 18000000
`define TAPER_TIME_MS 1800000

`endif

// ===== li_ion_charge_control_fsm.v
`timescale 1ns/10ps
`include "charge_ctrl_defs.vh"

// How it works
// - Below precharge threshold, apply reduced current
// - Precharge timer expiry stops charge, reports fault
// - USB rate: low 100mA, high 500mA, float off
// - Regulation voltage reached enters tapering phase
// - Charge timer expiry before taper gives fault
// - Taper level starts taper timer; expiry terminates
// - Current back above taper resets taper timer
// - Below termination level terminates at once
// - After done, recharge below recharge threshold
// - Both inputs absent means sleep
// - Status pins encode precharge, fast, done, fault
// - Power good on with input, off asleep
// - Charge enable high disables, low power
// - Charge enable falling edge clears timers, fault
// - Over-temperature suspends until cooled about 15C
// - Fault above recharge waits, then restarts
// - Fault below recharge applies removal probe current
// - AC preferred; USB only without AC
module li_ion_charge_control_fsm #(
   parameter [31:0] TICK_CYCLES = `TICK_CYCLES,
   parameter [31:0] PRECHARGE_MS = `PRECHARGE_TIME_MS,
   parameter [31:0] FASTCHARGE_MS = `FASTCHARGE_TIME_MS,
   parameter [31:0] TAPER_MS = `TAPER_TIME_MS
)(
   input wire sys_clk,
   input wire srst,
   input wire [7:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   output reg irq,
   input wire acPresent,
   input wire usbPresent,
   input wire usbRateSelectHigh,
   input wire usbRateSelectFloat,
   input wire chargeEnableN,
   input wire battBelowPrecharge,
   input wire battAtRegulation,
   input wire battBelowRecharge,
   input wire currentBelowTaper,
   input wire currentBelowTerm,
   input wire overTemp,
   input wire tempCooled,
   output reg chargeOn,
   output reg prechargeCurrent,
   output reg fullCurrent,
   output reg faultProbeOn,
   output reg sourceAc,
   output reg sourceUsb,
   output reg usbRate500,
   output reg lowPower,
   input wire statusOutAIn,
   output reg statusOutAOut,
   output reg statusOutAOeN,
   input wire statusOutBIn,
   output reg statusOutBOut,
   output reg statusOutBOeN,
   input wire powerGoodNIn,
   output reg powerGoodNOut,
   output reg powerGoodNOeN
);

   localparam [7:0] ST_SLEEP = 8'h01;
   localparam [7:0] ST_IDLE = 8'h02;
   localparam [7:0] ST_PRE = 8'h04;
   localparam [7:0] ST_FAST = 8'h08;
   localparam [7:0] ST_REG = 8'h10;
   localparam [7:0] ST_DONE = 8'h20;
   localparam [7:0] ST_FWAIT = 8'h40;
   localparam [7:0] ST_FPROBE = 8'h80;

   reg [7:0] state;
   reg [7:0] next_state;
   reg [7:0] startState;
   reg [7:0] faultState;
   reg ceNPrev;
   reg faultHeld;
   reg thermalSuspend;
   reg softSuspend;
   reg [31:0] tickCount;
   reg tick;
   reg [31:0] chargeTimer;
   reg [31:0] taperTimer;
   reg [`IRQ_WIDTH-1:0] irqStatus;
   reg [`IRQ_WIDTH-1:0] irqMask;
   reg [`IRQ_WIDTH-1:0] events;
   reg [31:0] regValue;
   reg accessDone;

   wire ceFall;
   wire suspend;
   wire sourceOk;
   wire charging;
   wire inFault;
   wire faultHeldEff;
   wire preExpired;
   wire chargeExpired;
   wire taperExpired;
   wire readClear;

   assign ceFall = ceNPrev & ~chargeEnableN;
   assign suspend = thermalSuspend | softSuspend;
   // USB counts only when its rate pin is not floating
   assign sourceOk = acPresent | (usbPresent & ~usbRateSelectFloat);
   assign charging = (state == ST_PRE) | (state == ST_FAST) | (state == ST_REG);
   assign inFault = (state == ST_FWAIT) | (state == ST_FPROBE);
   // Edge cancels a held fault in the same cycle it arrives
   assign faultHeldEff = faultHeld & ~ceFall;
   assign preExpired = chargeTimer >= PRECHARGE_MS;
   assign chargeExpired = chargeTimer >= FASTCHARGE_MS;
   assign taperExpired = taperTimer >= TAPER_MS;

   always @*
   begin
      startState = battBelowPrecharge ? ST_PRE : ST_FAST;
      faultState = battBelowRecharge ? ST_FPROBE : ST_FWAIT;
      next_state = state;
      if (!acPresent && !usbPresent)
      begin
         next_state = ST_SLEEP;
      end
      else if (chargeEnableN || !sourceOk)
      begin
         next_state = ST_IDLE;
      end
      else if (faultHeldEff && !inFault)
      begin
         next_state = faultState;
      end
      else
      begin
         case (state)
            ST_SLEEP, ST_IDLE:
            begin
               next_state = startState;
            end
            ST_PRE:
            begin
               if (!battBelowPrecharge)
                  next_state = ST_FAST;
               else if (preExpired)
                  next_state = faultState;
            end
            ST_FAST:
            begin
               if (currentBelowTerm)
                  next_state = ST_DONE;
               else if (chargeExpired)
                  next_state = faultState;
               else if (battAtRegulation)
                  next_state = ST_REG;
            end
            ST_REG:
            begin
               if (currentBelowTerm)
                  next_state = ST_DONE;
               else if (taperExpired)
                  next_state = ST_DONE;
               else if (chargeExpired && !currentBelowTaper && taperTimer == 32'h0)
                  next_state = faultState;
            end
            ST_DONE:
            begin
               if (battBelowRecharge)
                  next_state = startState;
            end
            ST_FWAIT:
            begin
               if (battBelowRecharge)
                  next_state = startState;
            end
            ST_FPROBE:
            begin
               if (!battBelowRecharge)
                  next_state = ST_FWAIT;
            end
            default:
            begin
               next_state = ST_SLEEP;
            end
         endcase
      end
   end

   always @(posedge sys_clk)
   begin
      if (srst)
      begin
         state <= ST_SLEEP;
         ceNPrev <= 1'b1;
         faultHeld <= 1'b0;
         thermalSuspend <= 1'b0;
      end
      else
      begin
         state <= next_state;
         ceNPrev <= chargeEnableN;
         if (!inFault && (next_state == ST_FWAIT || next_state == ST_FPROBE))
            faultHeld <= 1'b1;
         else if (ceFall || (state == ST_FWAIT && battBelowRecharge))
            faultHeld <= 1'b0;
         if (overTemp)
            thermalSuspend <= 1'b1;
         else if (tempCooled)
            thermalSuspend <= 1'b0;
      end
   end

   // Millisecond prescaler keeps the long timers within 32 bits
   always @(posedge sys_clk)
   begin
      if (srst)
      begin
         tickCount <= 32'h0;
         tick <= 1'b0;
      end
      else if (tickCount >= TICK_CYCLES - 32'h1)
      begin
         tickCount <= 32'h0;
         tick <= 1'b1;
      end
      else
      begin
         tickCount <= tickCount + 32'h1;
         tick <= 1'b0;
      end
   end

   // Timers pause while suspended so a hot cell is not faulted
   always @(posedge sys_clk)
   begin
      if (srst || ceFall)
      begin
         chargeTimer <= 32'h0;
         taperTimer <= 32'h0;
      end
      else
      begin
         if (!charging || (next_state != state && (next_state == ST_PRE || next_state == ST_FAST)))
            chargeTimer <= 32'h0;
         else if (tick && !suspend)
            chargeTimer <= chargeTimer + 32'h1;
         if (state != ST_REG || !currentBelowTaper)
            taperTimer <= 32'h0;
         else if (tick && !suspend)
            taperTimer <= taperTimer + 32'h1;
      end
   end

   always @(posedge sys_clk)
   begin
      if (srst)
      begin
         chargeOn <= 1'b0;
         prechargeCurrent <= 1'b0;
         fullCurrent <= 1'b0;
         faultProbeOn <= 1'b0;
         sourceAc <= 1'b0;
         sourceUsb <= 1'b0;
         usbRate500 <= 1'b0;
         lowPower <= 1'b1;
         statusOutAOut <= 1'b0;
         statusOutAOeN <= 1'b1;
         statusOutBOut <= 1'b0;
         statusOutBOeN <= 1'b1;
         powerGoodNOut <= 1'b0;
         powerGoodNOeN <= 1'b1;
      end
      else
      begin
         chargeOn <= charging & ~suspend;
         prechargeCurrent <= state == ST_PRE;
         fullCurrent <= (state == ST_FAST) | (state == ST_REG);
         faultProbeOn <= state == ST_FPROBE;
         sourceAc <= acPresent;
         sourceUsb <= ~acPresent & usbPresent & ~usbRateSelectFloat;
         usbRate500 <= usbRateSelectHigh & ~usbRateSelectFloat;
         lowPower <= (state == ST_SLEEP) | (state == ST_IDLE);
         statusOutAOut <= 1'b0;
         statusOutBOut <= 1'b0;
         powerGoodNOut <= 1'b0;
         statusOutAOeN <= ~charging;
         statusOutBOeN <= ~((state == ST_PRE) | (state == ST_DONE));
         powerGoodNOeN <= ~(acPresent | usbPresent) | (state == ST_SLEEP);
      end
   end

   always @*
   begin
      events = {`IRQ_WIDTH{1'b0}};
      events[`IRQ_FAULT] = ~inFault & ((next_state == ST_FWAIT) | (next_state == ST_FPROBE));
      events[`IRQ_DONE] = (state != ST_DONE) & (next_state == ST_DONE);
      events[`IRQ_SLEEP] = (state != ST_SLEEP) & (next_state == ST_SLEEP);
      events[`IRQ_THERMAL] = overTemp & ~thermalSuspend;
   end

   always @*
   begin
      regValue = 32'h0;
      case (avs_address)
         `REG_CTRL:
         begin
            regValue[`CTRL_SOFT_SUSPEND] = softSuspend;
         end
         `REG_STATUS:
         begin
            regValue[`STAT_STATE_LSB +: 8] = state;
            regValue[`STAT_FAULT_HELD] = faultHeld;
            regValue[`STAT_THERMAL] = thermalSuspend;
            regValue[`STAT_AC] = acPresent;
            regValue[`STAT_USB] = usbPresent;
            regValue[`STAT_PIN_A] = statusOutAIn;
            regValue[`STAT_PIN_B] = statusOutBIn;
            regValue[`STAT_PIN_PG] = powerGoodNIn;
         end
         `REG_IRQ_STATUS:
         begin
            regValue[`IRQ_WIDTH-1:0] = irqStatus;
         end
         `REG_IRQ_MASK:
         begin
            regValue[`IRQ_WIDTH-1:0] = irqMask;
         end
         default:
         begin
            regValue = 32'h0;
         end
      endcase
   end

   // Every access stalls one cycle; it completes on the edge with waitrequest low
   assign readClear = accessDone & avs_read & (avs_address == `REG_IRQ_STATUS);

   always @(posedge sys_clk)
   begin
      if (srst)
      begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0;
         accessDone <= 1'b0;
         softSuspend <= `CTRL_RESET;
         irqMask <= `IRQ_MASK_RESET;
         irqStatus <= {`IRQ_WIDTH{1'b0}};
         irq <= 1'b0;
      end
      else
      begin
         accessDone <= 1'b0;
         avs_waitrequest <= 1'b1;
         if ((avs_read || avs_write) && avs_waitrequest && !accessDone)
         begin
            avs_waitrequest <= 1'b0;
            accessDone <= 1'b1;
            avs_readdata <= avs_read ? regValue : 32'h0;
         end
         if (accessDone && avs_write && avs_address == `REG_CTRL)
            softSuspend <= avs_writedata[`CTRL_SOFT_SUSPEND];
         if (accessDone && avs_write && avs_address == `REG_IRQ_MASK)
            irqMask <= avs_writedata[`IRQ_WIDTH-1:0];
         // A new event wins over the read that clears
         irqStatus <= (readClear ? {`IRQ_WIDTH{1'b0}} : irqStatus) | events;
         irq <= |(irqStatus & irqMask);
      end
   end

endmodule

// ===== charge_supply_model.sv
`timescale 1ns/10ps
// Far side: rate pin driver and pull-ups on the open-drain lines
module charge_supply_model (
   input wire [1:0] rateLevel,
   input wire aOeN,
   input wire aOut,
   input wire bOeN,
   input wire bOut,
   input wire pgOeN,
   input wire pgOut,
   output wire rateHigh,
   output wire rateFloat,
   output wire pinA,
   output wire pinB,
   output wire pinPg
);
   // Rate pin: 0 low, 1 high, 2 released
   assign rateHigh = (rateLevel == 2'h1);
   assign rateFloat = (rateLevel == 2'h2);
   // Released line floats up, never keeps the last level
   assign pinA = aOeN ? 1'b1 : aOut;
   assign pinB = bOeN ? 1'b1 : bOut;
   assign pinPg = pgOeN ? 1'b1 : pgOut;
endmodule

// ===== charge_ctrl_checker.sv
`timescale 1ns/10ps
module charge_ctrl_checker (
   input wire sys_clk,
   input wire srst,
   input wire acPresent,
   input wire usbPresent,
   input wire usbRateSelectFloat,
   input wire chargeEnableN,
   input wire overTemp,
   input wire chargeOn,
   input wire prechargeCurrent,
   input wire fullCurrent,
   input wire faultProbeOn,
   input wire sourceAc,
   input wire sourceUsb,
   input wire lowPower,
   input wire statusOutAOeN,
   input wire statusOutBOeN,
   input wire powerGoodNOeN
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   // Three cycles cover the state edge plus the output lag
   sequence s_noSrc; (!acPresent && !usbPresent) [*3]; endsequence
   sequence s_src; (acPresent || usbPresent) [*3]; endsequence
   sequence s_off; chargeEnableN [*3]; endsequence
   sequence s_hot; overTemp [*3]; endsequence
   property p_sleep; s_noSrc |=> lowPower && !chargeOn && powerGoodNOeN; endproperty
   property p_pg; s_src |=> !powerGoodNOeN; endproperty
   property p_off; s_off |=> !chargeOn && lowPower; endproperty
   property p_hot; s_hot |=> !chargeOn; endproperty
   property p_pre; prechargeCurrent |-> !statusOutAOeN && !statusOutBOeN && !fullCurrent;
   endproperty
   property p_fast; fullCurrent |-> !statusOutAOeN && statusOutBOeN; endproperty
   property p_probe; faultProbeOn |-> statusOutAOeN && statusOutBOeN && !chargeOn; endproperty
   // Source flags lag the adapter inputs by exactly one clock
   property p_src; sourceUsb |-> !sourceAc && !$past(acPresent, 1); endproperty
   property p_usb; sourceUsb && chargeOn |-> !$past(usbRateSelectFloat, 2); endproperty
   a_sleep: assert property (p_sleep)
      else $error("sleep outputs wrong");
   a_pg: assert property (p_pg)
      else $error("power good off");
   a_off: assert property (p_off)
      else $error("charging while disabled");
   a_hot: assert property (p_hot)
      else $error("charging while hot");
   a_pre: assert property (p_pre)
      else $error("precharge pins wrong");
   a_fast: assert property (p_fast)
      else $error("fast pins wrong");
   a_probe: assert property (p_probe)
      else $error("probe pins wrong");
   a_src: assert property (p_src)
      else $error("usb chosen over ac");
   a_usb: assert property (p_usb)
      else $error("usb charge while floating");
endmodule

bind li_ion_charge_control_fsm charge_ctrl_checker u_chk (.*);

// ===== testbench.sv
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; \
   $display("[FAIL] %0t %h %h", $time, a, b); end end
module testbench;
   logic sys_clk = 0;
   logic srst = 1;
   logic [11:0] stim = 0;
   logic [7:0] avs_address = 0;
   logic avs_read = 0;
   logic avs_write = 0;
   logic [31:0] avs_writedata = 0;
   logic [31:0] q;
   wire [31:0] avs_readdata;
   wire avs_waitrequest, irq, chargeOn, prechargeCurrent, fullCurrent, faultProbeOn;
   wire sourceAc, sourceUsb, usbRate500, lowPower, rH, rF, pA, pB, pPg, aO, aE, bO, bE, gO, gE;
   wire [7:0] outs = {chargeOn, prechargeCurrent, fullCurrent, faultProbeOn, lowPower, aE, bE, gE};
   int mismatches = 0;
   int compares = 0;
   int cyc = 0;
   // Stimulus in the upper twelve bits, expected outputs below
   logic [19:0] rows [10] = '{20'h0000f, 20'h840c0, 20'h800a2, 20'h820a2, 20'h82404,
      20'h810a2, 20'h8900e, 20'h540c0, 20'h6400e, 20'h440c0};
   always #50 sys_clk = ~sys_clk;
   li_ion_charge_control_fsm #(.TICK_CYCLES(4), .PRECHARGE_MS(5), .FASTCHARGE_MS(20),
      .TAPER_MS(5)) u_dut (.*, .acPresent(stim[11]), .usbPresent(stim[10]),
      .usbRateSelectHigh(rH), .usbRateSelectFloat(rF), .chargeEnableN(stim[7]),
      .battBelowPrecharge(stim[6]), .battAtRegulation(stim[5]), .battBelowRecharge(stim[4]),
      .currentBelowTaper(stim[3]), .currentBelowTerm(stim[2]), .overTemp(stim[1]),
      .tempCooled(stim[0]), .statusOutAIn(pA), .statusOutAOut(aO), .statusOutAOeN(aE),
      .statusOutBIn(pB), .statusOutBOut(bO), .statusOutBOeN(bE), .powerGoodNIn(pPg),
      .powerGoodNOut(gO), .powerGoodNOeN(gE));
   charge_supply_model u_sup (.rateLevel(stim[9:8]), .aOeN(aE), .aOut(aO), .bOeN(bE),
      .bOut(bO), .pgOeN(gE), .pgOut(gO), .rateHigh(rH), .rateFloat(rF), .pinA(pA),
      .pinB(pB), .pinPg(pPg));
   task complete_run;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task go(input [11:0] s, input int n);
      @(posedge sys_clk);
      stim <= s;
      repeat (n) @(posedge sys_clk);
   endtask
   // No fixed latency assumed: wait for the slave's answer
   task bus(input w, input [7:0] a, input [31:0] d);
      @(posedge sys_clk);
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= d;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 0;
      avs_write <= 0;
   endtask
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         mismatches++;
         complete_run();
      end
   end
   initial
   begin
      repeat (8) @(posedge sys_clk);
      srst <= 0;
      foreach (rows[i])
      begin
         go(rows[i][19:8], 6);
         `CHK(outs, rows[i][7:0])
         $display("row %0d done", i);
      end
      srst <= 1;
      go(12'h000, 2);
      `CHK({irq, lowPower, aE, bE, gE, avs_waitrequest}, 6'h1f)
      srst <= 0;
      bus(0, 8'h04, 0);
      `CHK(q[14:0], 15'h7001)
      bus(0, 8'h40, 0);
      `CHK(q, 32'h0)
      bus(0, 8'h08, 0);
      go(12'h840, 4);
      go(12'h000, 6);
      `CHK(irq, 1'b0)
      bus(1, 8'h0c, 32'h4);
      go(12'h000, 3);
      `CHK(irq, 1'b1)
      bus(0, 8'h08, 0);
      `CHK(q[2], 1'b1)
      go(12'h000, 3);
      `CHK(irq, 1'b0)
      bus(0, 8'h0c, 0);
      `CHK(q, 32'h4)
      $display("bus done");
      go(12'h840, 40);
      `CHK({chargeOn, faultProbeOn, aE, bE}, 4'h3)
      go(12'h840, 20);
      `CHK(chargeOn, 1'b0)
      go(12'h850, 8);
      `CHK(chargeOn, 1'b1)
      go(12'h850, 40);
      `CHK({chargeOn, faultProbeOn, aE, bE}, 4'h7)
      go(12'h840, 6);
      `CHK({chargeOn, faultProbeOn}, 2'h0)
      go(12'h8c0, 3);
      go(12'h840, 6);
      `CHK(prechargeCurrent, 1'b1)
      $display("fault done");
      go(12'h400, 6);
      `CHK({sourceAc, sourceUsb, usbRate500, chargeOn}, 4'h5)
      go(12'h500, 6);
      `CHK(usbRate500, 1'b1)
      go(12'hc00, 6);
      `CHK({sourceAc, sourceUsb}, 2'h2)
      go(12'h802, 6);
      `CHK(chargeOn, 1'b0)
      go(12'h800, 6);
      `CHK(chargeOn, 1'b0)
      go(12'h801, 6);
      `CHK(chargeOn, 1'b1)
      // Soft suspend holds the state, so the pins keep showing fast charge
      bus(1, 8'h00, 32'h1);
      go(12'h801, 3);
      `CHK(chargeOn, 1'b0)
      bus(0, 8'h04, 0);
      `CHK(q[14:0], 15'h2408)
      `CHK({aO, bO, gO}, 3'h0)
      bus(0, 8'h00, 0);
      `CHK(q, 32'h1)
      bus(1, 8'h00, 32'h0);
      go(12'h801, 3);
      `CHK(chargeOn, 1'b1)
      $display("source done");
      // Enable toggle first so the charge timer cannot expire here
      go(12'h880, 2);
      go(12'h820, 4);
      go(12'h828, 10);
      go(12'h820, 2);
      // Long enough that a taper timer kept across the gap would expire
      go(12'h828, 16);
      `CHK(chargeOn, 1'b1)
      go(12'h828, 14);
      `CHK({chargeOn, bE}, 2'h0)
      go(12'h810, 100);
      `CHK({chargeOn, faultProbeOn, aE, bE}, 4'h7)
      $display("timer done");
      complete_run();
   end
endmodule
